//--- common/hbs_params.svh
// named offsets, codes and timing counts of the hub boot sequencer
// assumes inclusion by hbs_pkg and the sequencer only
`ifndef HBS_PARAMS_SVH
`define HBS_PARAMS_SVH
// ----------------------------------------
// spi rom probe
// ----------------------------------------
`define HBS_SIG 32'h32444655
`define HBS_PROBE_ADDR 24'h00fffa
`define HBS_EXEC_ADDR 16'h0000
`define HBS_CMD_READ 8'h03
`define HBS_CMD_DREAD 8'h3b
`define HBS_SPI_TX_BITS 7'h20
`define HBS_SPI_DUMMY 7'h08
`define HBS_SPI_RX_BITS 7'h20
`define HBS_SPI_RX_CLKS_DUAL 7'h10
`define HBS_SPI_HALF 4
// ----------------------------------------
// configuration image
// ----------------------------------------
`define HBS_CFG_DEPTH 256
`define HBS_SOC_DONE_ADDR 8'hff
`define HBS_BC_ADDR 8'h10
`define HBS_SMB_ADDR 8'h11
`define HBS_ROM_DEF_FILL 8'h00
`define HBS_ROM_DEF_SMB 8'h01
// ----------------------------------------
// charge strap resistor classes
// ----------------------------------------
`define HBS_RES_PD200K 3'h0
`define HBS_RES_PU200K 3'h1
`define HBS_RES_PD10K 3'h2
`define HBS_RES_PU10K 3'h3
`define HBS_RES_PD10R 3'h4
`define HBS_STRAP_SETTLE 2'h3
`endif

//--- common/hbs_pkg.sv
// types shared by the hub boot sequencer files
// assumes hbs_params.svh sits beside it on the include path
`include "hbs_params.svh"
package hbs_pkg;
  typedef logic [2:0] hbs_res_t;
  typedef logic [7:0] hbs_addr_t;
  typedef logic [7:0] hbs_byte_t;
  typedef logic [3:0] hbs_port_t;
  typedef enum logic [9:0] {
    HBS_STANDBY = 10'h001,
    HBS_SPI_INIT = 10'h002,
    HBS_CFG_RD = 10'h004,
    HBS_STRAP = 10'h008,
    HBS_SOC_CFG = 10'h010,
    HBS_OTP_CFG = 10'h020,
    HBS_SUSPEND = 10'h040,
    HBS_CHARGER_DETECT_STAGE = 10'h080,
    HBS_CONNECT = 10'h100,
    HBS_NORMAL = 10'h200
  } hbs_state_e;
endpackage : hbs_pkg

//--- logic/hbs_cfg_mem.sv
// configuration image memory, one write and one registered read port
// assumes a single clock; contents are rebuilt on every boot
`timescale 1ns/10ps
module hbs_cfg_mem #(
  parameter int DEPTH = 256,
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  // no reset on the array: it is a ram, the default load rewrites it
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : hbs_cfg_mem

//--- logic/hub_boot_sequencer.sv
// hub boot sequencer: standby, rom probe, default load, straps, soc
// configuration, merge, charger detection, connect and normal stages
// assumes the smbus slave, otp array and usb core sit on sys_clk
`timescale 1ns/10ps
`include "hbs_params.svh"
module hub_boot_sequencer #(
  parameter int SPI_HALF = `HBS_SPI_HALF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // strap pins
  input wire hbs_pkg::hbs_res_t charge_port_count_strap,
  input wire logic strap_do_pullup,
  input wire logic strap_clk_pullup,
  // spi rom configuration
  input wire logic spi_dual,
  input wire logic spi_cpol,
  // spi rom pins
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_io0_out,
  output logic spi_io0_oe,
  input wire logic spi_io0_in,
  input wire logic spi_io1_in,
  output logic ext_rom_en,
  output logic [15:0] ext_exec_addr,
  // soc configuration from the smbus slave
  input wire logic soc_wr,
  input wire hbs_pkg::hbs_addr_t soc_addr,
  input wire hbs_pkg::hbs_byte_t soc_wdata,
  output logic soc_stage,
  output logic smbus_mode,
  // otp read port
  output hbs_pkg::hbs_addr_t otp_addr,
  input wire hbs_pkg::hbs_byte_t otp_data,
  input wire logic otp_valid,
  // programming of the merged image
  output logic prog_we,
  output hbs_pkg::hbs_addr_t prog_addr,
  output hbs_pkg::hbs_byte_t prog_data,
  // usb side
  input wire logic vbus_pin,
  input wire logic soft_disconnect,
  input wire logic host_link_up,
  input wire logic charger_detect_stage_done,
  output logic charger_detect_stage_start,
  output logic usb_attach,
  output logic hub_suspend,
  output logic pll_en,
  output logic usb_pins_oe,
  output hbs_pkg::hbs_port_t ds_port_en,
  output hbs_pkg::hbs_port_t bc_port_en,
  output hbs_pkg::hbs_state_e boot_state
);
  import hbs_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  assign pin_raw = {charge_port_count_strap, strap_do_pullup, strap_clk_pullup,
                    vbus_pin, spi_io1_in};
  logic io0_s1_r;
  logic io0_s2_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      io0_s1_r <= 1'b0;
      io0_s2_r <= 1'b0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      io0_s1_r <= spi_io0_in;
      io0_s2_r <= io0_s1_r;
    end
  end

  wire hbs_res_t bc_code_s = sync2_r[6:4];
  wire do_pu_s = sync2_r[3];
  wire clk_pu_s = sync2_r[2];
  wire vbus_s = sync2_r[1];
  wire io1_s = sync2_r[0];

  // ----------------------------------------
  // state and strap latch
  // ----------------------------------------
  hbs_state_e state_r;
  hbs_state_e state_nxt;
  logic [1:0] settle_r;
  hbs_res_t bc_code_lat_r;
  logic smb_lat_r;
  logic smbus_mode_r;
  hbs_port_t bc_cfg_r;

  wire settled = (settle_r == `HBS_STRAP_SETTLE);
  wire st_standby = (state_r == HBS_STANDBY);
  wire st_spi = (state_r == HBS_SPI_INIT);
  wire st_cfg = (state_r == HBS_CFG_RD);
  wire st_soc = (state_r == HBS_SOC_CFG);
  wire st_otp = (state_r == HBS_OTP_CFG);

  // resistor class to charging port set; unknown classes charge nothing
  hbs_port_t bc_strap_mask;
  assign bc_strap_mask = (bc_code_lat_r == `HBS_RES_PU200K) ? 4'h1 :
                         (bc_code_lat_r == `HBS_RES_PD10K) ? 4'h3 :
                         (bc_code_lat_r == `HBS_RES_PU10K) ? 4'h7 :
                         (bc_code_lat_r == `HBS_RES_PD10R) ? 4'hf : 4'h0;

  // straps only settle once both sync stages hold post-release levels
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      settle_r <= 2'h0;
      bc_code_lat_r <= `HBS_RES_PD200K;
      smb_lat_r <= 1'b0;
    end else if (st_standby) begin
      settle_r <= settle_r + 2'h1;
      if (settled) begin
        bc_code_lat_r <= bc_code_s;
        smb_lat_r <= do_pu_s & clk_pu_s;
      end
    end
  end

  // ----------------------------------------
  // spi rom probe engine
  // ----------------------------------------
  logic spi_busy_r;
  logic spi_done_r;
  logic [3:0] spi_div_r;
  logic sclk_r;
  logic [6:0] bit_r;
  logic [31:0] tx_r;
  logic [31:0] rx_r;
  logic ext_rom_en_r;
  logic [15:0] ext_exec_addr_r;

  wire [6:0] rx_start = `HBS_SPI_TX_BITS + (spi_dual ? `HBS_SPI_DUMMY : 7'h00);
  wire [6:0] total_clks = rx_start + (spi_dual ? `HBS_SPI_RX_CLKS_DUAL : `HBS_SPI_RX_BITS);
  wire spi_go = st_spi & ~smb_lat_r & ~spi_busy_r & ~spi_done_r;
  wire half_tick = spi_busy_r & (spi_div_r == 4'(SPI_HALF - 1));
  wire rise = half_tick & ~sclk_r;
  wire fall = half_tick & sclk_r;
  wire last_fall = fall & (bit_r == total_clks - 7'h01);
  wire sig_ok = (rx_r == `HBS_SIG);
  wire [31:0] rx_shift = spi_dual ? {rx_r[29:0], io1_s, io0_s2_r} : {rx_r[30:0], io1_s};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      spi_busy_r <= 1'b0;
      spi_div_r <= 4'h0;
      sclk_r <= 1'b0;
      bit_r <= 7'h00;
      tx_r <= 32'h0;
      rx_r <= 32'h0;
    end else if (spi_go) begin
      spi_busy_r <= 1'b1;
      spi_div_r <= 4'h0;
      sclk_r <= 1'b0;
      bit_r <= 7'h00;
      tx_r <= {spi_dual ? `HBS_CMD_DREAD : `HBS_CMD_READ, `HBS_PROBE_ADDR};
    end else if (spi_busy_r) begin
      spi_div_r <= half_tick ? 4'h0 : spi_div_r + 4'h1;
      if (half_tick) begin
        sclk_r <= ~sclk_r;
      end
      if (rise && bit_r >= rx_start) begin
        rx_r <= rx_shift;
      end
      if (fall) begin
        bit_r <= bit_r + 7'h01;
        tx_r <= {tx_r[30:0], 1'b0};
      end
      if (last_fall) begin
        spi_busy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      spi_done_r <= 1'b0;
      ext_rom_en_r <= 1'b0;
      ext_exec_addr_r <= 16'h0;
    end else if (last_fall) begin
      spi_done_r <= 1'b1;
    end else if (st_spi && spi_done_r) begin
      spi_done_r <= 1'b0;
      ext_rom_en_r <= sig_ok;
      ext_exec_addr_r <= `HBS_EXEC_ADDR;
    end
  end

  // mode 3 idles the clock high; data is still sampled on the rising edge
  assign spi_cs_n = ~spi_busy_r;
  assign spi_sclk = spi_busy_r ? sclk_r : spi_cpol;
  assign spi_io0_out = tx_r[31];
  assign spi_io0_oe = spi_busy_r & (~spi_dual | (bit_r < `HBS_SPI_TX_BITS));
  assign ext_rom_en = ext_rom_en_r;
  assign ext_exec_addr = ext_exec_addr_r;

  // ----------------------------------------
  // configuration image: default load, soc writes, merge
  // ----------------------------------------
  logic [8:0] ld_addr_r;
  logic [8:0] mg_addr_r;
  logic mg_ph_r;
  logic [`HBS_CFG_DEPTH-1:0] soc_written_r;
  hbs_byte_t mem_rdata;
  logic prog_we_r;
  hbs_addr_t prog_addr_r;
  hbs_byte_t prog_data_r;

  wire ld_last = ld_addr_r[8];
  wire soc_done = st_soc & soc_wr & (soc_addr == `HBS_SOC_DONE_ADDR);
  wire soc_store = st_soc & soc_wr & ~soc_done;
  wire mg_end = st_otp & mg_ph_r & (mg_addr_r[7:0] == 8'hff);
  wire hbs_addr_t ld_a = ld_addr_r[7:0];
  wire hbs_addr_t mg_a = mg_addr_r[7:0];
  wire hbs_byte_t rom_def = (ld_a == `HBS_SMB_ADDR) ? `HBS_ROM_DEF_SMB : `HBS_ROM_DEF_FILL;
  wire hbs_byte_t strap_ovr = {4'h0, bc_strap_mask};
  wire mem_we = st_cfg | soc_store;
  wire hbs_addr_t mem_waddr = st_cfg ? (ld_last ? `HBS_BC_ADDR : ld_a) : soc_addr;
  wire hbs_byte_t mem_wdata = st_cfg ? (ld_last ? strap_ovr : rom_def) : soc_wdata;
  wire hbs_byte_t merged = soc_written_r[mg_a] ? mem_rdata :
                           (otp_valid ? otp_data : mem_rdata);

  hbs_cfg_mem #(
    .DEPTH(`HBS_CFG_DEPTH),
    .AW(8),
    .DW(8)
  ) u_cfg_mem (
    .clk(sys_clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mg_a),
    .rdata(mem_rdata)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ld_addr_r <= 9'h000;
      soc_written_r <= '0;
    end else if (st_cfg) begin
      ld_addr_r <= ld_addr_r + 9'h001;
      soc_written_r <= '0;
    end else if (soc_store) begin
      soc_written_r[soc_addr] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mg_addr_r <= 9'h000;
      mg_ph_r <= 1'b0;
      prog_we_r <= 1'b0;
      prog_addr_r <= 8'h00;
      prog_data_r <= 8'h00;
      bc_cfg_r <= 4'h0;
    end else begin
      prog_we_r <= st_otp & mg_ph_r;
      if (st_otp) begin
        mg_ph_r <= ~mg_ph_r;
        if (mg_ph_r) begin
          mg_addr_r <= mg_addr_r + 9'h001;
          prog_addr_r <= mg_a;
          prog_data_r <= merged;
          if (mg_a == `HBS_BC_ADDR) begin
            bc_cfg_r <= merged[3:0];
          end
        end
      end
    end
  end

  assign otp_addr = mg_a;
  assign prog_we = prog_we_r;
  assign prog_addr = prog_addr_r;
  assign prog_data = prog_data_r;

  // ----------------------------------------
  // boot stage sequencing
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      HBS_STANDBY: begin
        if (settled) state_nxt = HBS_SPI_INIT;
      end
      HBS_SPI_INIT: begin
        if (smb_lat_r) state_nxt = HBS_CFG_RD;
        else if (spi_done_r) state_nxt = HBS_CFG_RD;
      end
      HBS_CFG_RD: begin
        if (ld_last) state_nxt = HBS_STRAP;
      end
      HBS_STRAP: begin
        state_nxt = smb_lat_r ? HBS_SOC_CFG : HBS_OTP_CFG;
      end
      HBS_SOC_CFG: begin
        if (soc_done) state_nxt = HBS_OTP_CFG;
      end
      HBS_OTP_CFG: begin
        if (mg_end) state_nxt = HBS_SUSPEND;
      end
      HBS_SUSPEND: begin
        if (vbus_s) state_nxt = (|bc_cfg_r) ? HBS_CHARGER_DETECT_STAGE : HBS_CONNECT;
      end
      HBS_CHARGER_DETECT_STAGE: begin
        if (charger_detect_stage_done) state_nxt = HBS_CONNECT;
      end
      HBS_CONNECT: begin
        if (!vbus_s) state_nxt = HBS_SUSPEND;
        else if (host_link_up && !soft_disconnect) state_nxt = HBS_NORMAL;
      end
      HBS_NORMAL: begin
        if (soft_disconnect || !vbus_s) state_nxt = HBS_CONNECT;
      end
      default: begin
        state_nxt = HBS_STANDBY;
      end
    endcase
  end

  // asynchronous low reset is the standby mode itself
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= HBS_STANDBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      smbus_mode_r <= 1'b0;
    end else if (state_r == HBS_STRAP) begin
      smbus_mode_r <= smb_lat_r;
    end
  end

  // ----------------------------------------
  // stage outputs
  // ----------------------------------------
  wire configured = (state_r == HBS_SUSPEND) | (state_r == HBS_CHARGER_DETECT_STAGE) |
                    (state_r == HBS_CONNECT) | (state_r == HBS_NORMAL);
  assign pll_en = ~st_standby;
  assign usb_pins_oe = configured;
  assign ds_port_en = configured ? 4'hf : 4'h0;
  assign bc_port_en = configured ? bc_cfg_r : 4'h0;
  assign hub_suspend = (state_r == HBS_SUSPEND) & ~vbus_s;
  assign charger_detect_stage_start = (state_r == HBS_CHARGER_DETECT_STAGE);
  assign usb_attach = ((state_r == HBS_CONNECT) & vbus_s & ~soft_disconnect) |
                      (state_r == HBS_NORMAL);
  assign soc_stage = st_soc;
  assign smbus_mode = smbus_mode_r;
  assign boot_state = state_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_soft_held;
    soft_disconnect && vbus_s;
  endsequence

  a_standby_quiet: assert property (st_standby |-> !pll_en && !usb_pins_oe && ds_port_en == 4'h0)
    else $error("standby left pll, pins or ports active");
  a_release_probe: assert property (st_standby && settled |=> state_r == HBS_SPI_INIT)
    else $error("release did not enter rom probe");
  a_smbus_skip: assert property (st_spi && smb_lat_r |=> st_cfg && spi_cs_n)
    else $error("smbus strap did not skip the probe");
  a_sig_enable: assert property ($rose(ext_rom_en) |-> $past(sig_ok) && ext_exec_addr == `HBS_EXEC_ADDR)
    else $error("external rom enabled without signature");
  a_strap_route: assert property (state_r == HBS_STRAP |=> smb_lat_r ? st_soc : st_otp)
    else $error("strap stage took the wrong branch");
  a_soc_wait: assert property (st_soc && !soc_done |=> st_soc)
    else $error("soc stage left without end write");
  a_soc_end: assert property (soc_done |=> st_otp ##1 !soc_stage)
    else $error("end write did not close soc stage");
  a_vbus_route: assert property (state_r == HBS_SUSPEND && vbus_s |=>
    state_r == ((|bc_cfg_r) ? HBS_CHARGER_DETECT_STAGE : HBS_CONNECT))
    else $error("vbus arrival took the wrong stage");
  a_soft_disc: assert property (state_r == HBS_NORMAL ##1 s_soft_held [*2] |->
    state_r == HBS_CONNECT && !usb_attach)
    else $error("soft disconnect did not hold connect stage");
  a_bc_decode: assert property (bc_code_lat_r == `HBS_RES_PD10K |-> bc_strap_mask == 4'h3)
    else $error("charge strap decoded wrongly");
endmodule : hub_boot_sequencer

//--- verif/hbs_rom_model.sv
// behavioural serial boot rom facing the sequencer's rom pins
// assumes the bench resolves io0 from the sequencer's enable
`timescale 1ns/10ps
module hbs_rom_model (
  // rom pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic io0_out,
  output logic io0,
  output logic io1,
  // test control and observation
  input wire logic sig_good,
  output logic [7:0] got_cmd,
  output logic [23:0] got_addr
);
  // ----------------------------------------
  // shift in command and address, answer from the image
  // ----------------------------------------
  logic [31:0] sh;
  logic [31:0] word;
  int nr;
  initial begin
    io0 = 1'b0;
    io1 = 1'b1;
    nr = 0;
    sh = 32'h0;
    got_cmd = 8'h00;
    got_addr = 24'h000000;
  end
  // "2DFU" only at the probe address; bad image differs in one bit only
  assign word = (sig_good && got_addr == 24'h00fffa) ? 32'h32444655 : 32'h32444654;
  always @(negedge cs_n) nr = 0;
  // released lines have no pull: show the inverse of the last level
  always @(posedge cs_n) begin
    io0 = ~io0;
    io1 = ~io1;
  end
  // both supported modes sample on the rising clock edge
  always @(posedge sclk) if (!cs_n) begin
    if (nr < 32) sh = {sh[30:0], io0_out};
    nr = nr + 1;
    if (nr == 32) begin
      got_cmd = sh[31:24];
      got_addr = sh[23:0];
    end
  end
  always @(negedge sclk) if (!cs_n) begin
    if (got_cmd == 8'h03 && nr >= 32 && nr < 64) begin
      io1 = word[63-nr];
    end else if (got_cmd == 8'h3b && nr >= 40 && nr < 56) begin
      io1 = word[2*(55-nr)+1];
      io0 = word[2*(55-nr)];
    end else begin
      io0 = ~io0;
      io1 = ~io1;
    end
  end
endmodule : hbs_rom_model

//--- verif/hub_boot_sequencer_test.sv
// self-checking bench for the hub boot sequencer
// assumes hbs_pkg compiled first; smbus slave and otp played by the bench
`timescale 1ns/10ps
module hub_boot_sequencer_test;
  import hbs_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic sys_clk, resetn, strap_do_pullup, strap_clk_pullup, spi_dual, spi_cpol;
  hbs_res_t charge_port_count_strap;
  logic spi_cs_n, spi_sclk, spi_io0_out, spi_io0_oe, spi_io0_in, spi_io1_in, ext_rom_en;
  logic [15:0] ext_exec_addr;
  logic soc_wr, soc_stage, smbus_mode, otp_valid, prog_we;
  hbs_addr_t soc_addr, otp_addr, prog_addr;
  hbs_byte_t soc_wdata, otp_data, prog_data;
  logic vbus_pin, soft_disconnect, host_link_up, charger_detect_stage_done, charger_detect_stage_start;
  logic usb_attach, hub_suspend, pll_en, usb_pins_oe;
  hbs_port_t ds_port_en, bc_port_en;
  hbs_state_e boot_state;
  logic rom_io0, rom_io1, sig_good;
  logic [7:0] got_cmd;
  logic [23:0] got_addr;
  logic [7:0] img [256];
  logic [3:0] mask_tab [6] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf, 4'h0};
  int mismatches = 0;
  int tests_run = 0;
  int cs_lo = 0;
  logic good;
  always #5 sys_clk = ~sys_clk;
  assign spi_io0_in = spi_io0_oe ? spi_io0_out : rom_io0;
  assign spi_io1_in = rom_io1;
  always @(negedge spi_cs_n) cs_lo++;
  always @(posedge sys_clk) if (prog_we === 1'b1) img[prog_addr] <= prog_data;
  // otp holds a byte only at 0x20, answered half a cycle after the address
  always @(negedge sys_clk) begin
    otp_data <= otp_addr ^ 8'h5a;
    otp_valid <= (otp_addr == 8'h20);
  end
  hub_boot_sequencer DUT (.sys_clk(sys_clk), .resetn(resetn),
    .charge_port_count_strap(charge_port_count_strap), .strap_do_pullup(strap_do_pullup),
    .strap_clk_pullup(strap_clk_pullup), .spi_dual(spi_dual), .spi_cpol(spi_cpol),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_io0_out(spi_io0_out),
    .spi_io0_oe(spi_io0_oe), .spi_io0_in(spi_io0_in), .spi_io1_in(spi_io1_in),
    .ext_rom_en(ext_rom_en), .ext_exec_addr(ext_exec_addr), .soc_wr(soc_wr),
    .soc_addr(soc_addr), .soc_wdata(soc_wdata), .soc_stage(soc_stage),
    .smbus_mode(smbus_mode), .otp_addr(otp_addr), .otp_data(otp_data),
    .otp_valid(otp_valid), .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data),
    .vbus_pin(vbus_pin), .soft_disconnect(soft_disconnect), .host_link_up(host_link_up),
    .charger_detect_stage_done(charger_detect_stage_done), .charger_detect_stage_start(charger_detect_stage_start), .usb_attach(usb_attach),
    .hub_suspend(hub_suspend), .pll_en(pll_en), .usb_pins_oe(usb_pins_oe),
    .ds_port_en(ds_port_en), .bc_port_en(bc_port_en), .boot_state(boot_state));
  hbs_rom_model rom (.cs_n(spi_cs_n), .sclk(spi_sclk), .io0_out(spi_io0_out), .io0(rom_io0),
    .io1(rom_io1), .sig_good(sig_good), .got_cmd(got_cmd), .got_addr(got_addr));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // bounded wait; a state that never comes shows up as a mismatch
  task automatic wait_st(input hbs_state_e st, input int lim);
    int n;
    n = 0;
    while (boot_state !== st && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    chk("boot_state", st, boot_state);
  endtask : wait_st
  task automatic soc_write(input hbs_addr_t a, input hbs_byte_t d);
    @(negedge sys_clk);
    soc_wr = 1'b1;
    soc_addr = a;
    soc_wdata = d;
    @(negedge sys_clk);
    soc_wr = 1'b0;
  endtask : soc_write
  // straps settle during reset so the synchronisers see them early
  task automatic boot_rst(input hbs_res_t cls, input logic pu, dual, cpol, ok);
    @(negedge sys_clk);
    resetn = 1'b0;
    charge_port_count_strap = cls;
    strap_do_pullup = pu;
    strap_clk_pullup = pu;
    spi_dual = dual;
    spi_cpol = cpol;
    sig_good = ok;
    vbus_pin = 1'b0;
    soft_disconnect = 1'b0;
    host_link_up = 1'b0;
    charger_detect_stage_done = 1'b0;
    for (int i = 0; i < 256; i++) img[i] = 8'hee;
    repeat (16) @(negedge sys_clk);
    chk("standby", HBS_STANDBY, boot_state);
    chk("standby outputs", 8'h01, {pll_en, usb_pins_oe, ds_port_en, ext_rom_en, spi_cs_n});
    chk("standby charge mask", 4'h0, bc_port_en);
    cs_lo = 0;
    resetn = 1'b1;
    wait_st(HBS_SPI_INIT, 8);
  endtask : boot_rst
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #400000;
    mismatches++;
    $display("BAD watchdog expected finish seen timeout");
    stop_test();
  end
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    {strap_do_pullup, strap_clk_pullup, spi_dual, spi_cpol, sig_good} = 5'h0;
    charge_port_count_strap = 3'h0;
    {soc_wr, vbus_pin, soft_disconnect, host_link_up, charger_detect_stage_done} = 5'h0;
    soc_addr = 8'h00;
    soc_wdata = 8'h00;
    // smbus boot, soc rewrites, late strap change, usb stage walk
    boot_rst(3'h3, 1'b1, 1'b0, 1'b0, 1'b1);
    wait_st(HBS_CFG_RD, 20);
    wait_st(HBS_STRAP, 600);
    wait_st(HBS_SOC_CFG, 10);
    chk("smbus_mode", 1, smbus_mode);
    chk("soc_stage", 1, soc_stage);
    chk("rom selects", 0, cs_lo);
    charge_port_count_strap = 3'h4;
    repeat (1500) @(negedge sys_clk);
    chk("soc stage held", HBS_SOC_CFG, boot_state);
    soc_write(8'h30, 8'h3c);
    soc_write(8'h20, 8'h99);
    soc_write(8'hff, 8'ha5);
    chk("end of soc stage", HBS_OTP_CFG, boot_state);
    wait_st(HBS_SUSPEND, 700);
    // last programmed byte lands one edge after the stage change
    @(negedge sys_clk);
    chk("img 30", 8'h3c, img[8'h30]);
    chk("img 20", 8'h99, img[8'h20]);
    chk("img ff", 8'h00, img[8'hff]);
    chk("img 10", 4'h7, img[8'h10][3:0]);
    chk("bc_port_en", 4'h7, bc_port_en);
    chk("hub_suspend", 1, hub_suspend);
    chk("configured", 6'h3f, {pll_en, usb_pins_oe, ds_port_en});
    vbus_pin = 1'b1;
    wait_st(HBS_CHARGER_DETECT_STAGE, 8);
    chk("charger_detect_stage_start", 1, charger_detect_stage_start);
    charger_detect_stage_done = 1'b1;
    wait_st(HBS_CONNECT, 8);
    chk("usb_attach", 1, usb_attach);
    host_link_up = 1'b1;
    wait_st(HBS_NORMAL, 8);
    soft_disconnect = 1'b1;
    wait_st(HBS_CONNECT, 8);
    chk("attach dropped", 0, usb_attach);
    repeat (20) @(negedge sys_clk);
    chk("held in connect", HBS_CONNECT, boot_state);
    soft_disconnect = 1'b0;
    wait_st(HBS_NORMAL, 8);
    vbus_pin = 1'b0;
    wait_st(HBS_SUSPEND, 12);
    $display("test smbus boot done");
    // spi boots over every strap class, both widths, both modes
    for (int i = 0; i < 6; i++) begin
      good = !(i == 1 || i == 4);
      boot_rst(i[2:0], 1'b0, i[0], i[1], good);
      chk("sclk idle", i[1], spi_sclk);
      wait_st(HBS_CFG_RD, 700);
      chk("ext_rom_en", good, ext_rom_en);
      chk("ext_exec_addr", 16'h0000, ext_exec_addr);
      chk("rom command", i[0] ? 8'h3b : 8'h03, got_cmd);
      chk("rom address", 24'h00fffa, got_addr);
      chk("rom selects", 1, cs_lo);
      wait_st(HBS_STRAP, 600);
      wait_st(HBS_OTP_CFG, 8);
      chk("smbus_mode", 0, smbus_mode);
      wait_st(HBS_SUSPEND, 700);
      @(negedge sys_clk);
      chk("bc_port_en", mask_tab[i], bc_port_en);
      chk("img 30", 8'h00, img[8'h30]);
      chk("img 20", 8'h7a, img[8'h20]);
      vbus_pin = 1'b1;
      wait_st(mask_tab[i] != 4'h0 ? HBS_CHARGER_DETECT_STAGE : HBS_CONNECT, 8);
      charger_detect_stage_done = 1'b1;
      wait_st(HBS_CONNECT, 8);
      host_link_up = 1'b1;
      wait_st(HBS_NORMAL, 8);
      $display("test spi boot %0d done", i);
    end
    stop_test();
  end
endmodule : hub_boot_sequencer_test
